// [logic/dmm_data_memory_map.v]
// Functional notes
// - lower 128 bytes 00h-7Fh serve both direct and indirect access.
// - lowest 32 bytes form four banks of eight working registers.
// - status bits 4:3 choose bank at 00h, 08h, 10h or 18h.
// - 16 bytes above banks hold bit addresses 00h-7Fh.
// - upper 128 bytes 80h-FFh reachable only indirectly.
// - direct accesses at 80h-FFh go to special function registers.
// - 256-byte expanded ram at 0000h-00FFh via external-data moves only.
// - two 16-bit pointers both appear at addresses 83h and 84h.
// - pointer select bit 0 picks second pointer when one.
// - auxiliary bit 2 always reads zero, shielding flag three from carries.
// - incrementing auxiliary register toggles the pointer select bit.
// - boot flash mapped at F800h-FFFFh while boot enable bit set.
// - auxiliary bit 3 is a free software flag.
// - parity bit is high when accumulator has odd count of ones.
// - carry, auxiliary carry and overflow updated from arithmetic results.
// - status bits 5 and 1 are free user flags.
// - status word clears fully at reset, selecting bank zero.
// - auxiliary register resets with pointer select and zero bit cleared.
// - boot enable resets to zero, then takes inverse of boot loader jump setting on first clock after reset release.
`timescale 1ns/1ps
`include "dmm_regs.vh"
module dmm_data_memory_map (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // boot configuration, held stable by the core
  input wire boot_loader_jump_config,
  // internal data access: direct, indirect or register form
  input wire mem_req,
  input wire mem_write,
  input wire mem_indirect,
  input wire mem_reg_form,
  input wire [2:0] mem_reg_index,
  input wire [7:0] mem_addr,
  input wire [7:0] mem_wr_data,
  output reg [7:0] mem_rd_data_q,
  output reg mem_sfr_hit_q,
  // bit access to the bit-addressable area
  input wire bit_req,
  input wire bit_write,
  input wire [6:0] bit_addr,
  input wire bit_wr_data,
  output reg bit_rd_data_q,
  // expanded ram via external-data moves
  input wire xmem_req,
  input wire xmem_write,
  input wire [15:0] xmem_addr,
  input wire [7:0] xmem_wr_data,
  output reg [7:0] xmem_rd_data_q,
  output reg xmem_hit_q,
  // data pointer increment and auxiliary increment
  input wire dp_incr,
  input wire aux_incr,
  // alu flag updates
  input wire [7:0] accumulator_register,
  input wire alu_flag_we,
  input wire carry_in,
  input wire aux_carry_in,
  input wire overflow_in,
  // code space boot decode
  input wire [15:0] code_addr,
  output reg boot_flash_sel_q,
  // state shown to the core
  output reg [15:0] active_data_pointer_q,
  output reg [7:0] processor_status_word_q,
  output reg [7:0] auxiliary_control_one_q
);
  reg [7:0] psw_q;
  reg [7:0] psw_d;
  reg pointer_select_q;
  reg general_flag_three_q;
  reg boot_flash_map_enable_q;
  reg boot_loaded_q;
  wire [15:0] first_data_pointer;
  wire [15:0] second_data_pointer;
  wire [15:0] dp_sel;
  wire [1:0] bank;
  reg [7:0] iram_addr;
  reg iram_we;
  wire [7:0] iram_rd;
  wire direct_upper;
  wire sfr_wr;
  wire [7:0] aux_view;
  wire [7:0] bit_byte_addr;
  wire [7:0] bit_mask;
  wire expanded_ram_hit;
  wire [7:0] expanded_ram_rd;
  wire parity;
  wire [31:0] dp_bank;
  wire [7:0] iram_wd;
  wire psw_wr;
  wire aux_wr;
  reg sfr_dp_high;
  reg sfr_dp_low;
  reg sfr_aux;
  reg sfr_status;

  assign bank = {psw_q[`DMM_PSW_BANK_HIGH], psw_q[`DMM_PSW_BANK_LOW]};
  assign direct_upper = mem_req && !mem_indirect && !mem_reg_form && mem_addr[7];
  assign sfr_wr = direct_upper && mem_write;
  assign parity = ^accumulator_register;
  // bits 7:6, 4 and 1 read zero; bit 2 is stuck low so an increment never reaches flag three
  assign aux_view = {2'b00, boot_flash_map_enable_q, 1'b0, general_flag_three_q, 1'b0, 1'b0,
    pointer_select_q};
  assign bit_byte_addr = `DMM_BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
  assign bit_mask = 8'h01 << bit_addr[2:0];
  assign expanded_ram_hit = xmem_req && (xmem_addr[15:8] == 8'h00);
  assign psw_wr = sfr_wr && sfr_status;
  assign aux_wr = sfr_wr && sfr_aux;
  // a bit write is a read-modify-write of its byte through the one port, so byte traffic must win
  assign iram_wd = mem_req ? mem_wr_data : (bit_wr_data ? (iram_rd | bit_mask) : (iram_rd & ~bit_mask));

  // direct upper decode; only four registers live in this block, the rest read zero
  always @*
  begin
    sfr_dp_high = 1'b0;
    sfr_dp_low = 1'b0;
    sfr_aux = 1'b0;
    sfr_status = 1'b0;
    if (direct_upper && mem_addr == `DMM_ADDR_DP_HIGH)
      sfr_dp_high = 1'b1;
    else if (direct_upper && mem_addr == `DMM_ADDR_DP_LOW)
      sfr_dp_low = 1'b1;
    else if (direct_upper && mem_addr == `DMM_ADDR_AUX_CTRL)
      sfr_aux = 1'b1;
    else if (direct_upper && mem_addr == `DMM_ADDR_STATUS)
      sfr_status = 1'b1;
  end

  // single internal ram port; bit access takes it when no byte access is pending
  always @*
  begin
    iram_addr = mem_addr;
    iram_we = 1'b0;
    if (mem_req && mem_reg_form)
    begin
      iram_addr = {3'b000, bank, mem_reg_index};
      iram_we = mem_write;
    end
    else if (mem_req && !direct_upper)
    begin
      iram_addr = mem_addr;
      iram_we = mem_write;
    end
    else if (!mem_req && bit_req)
    begin
      iram_addr = bit_byte_addr;
      iram_we = bit_write;
    end
  end

  dmm_ram #(
    .AW(8),
    .DEPTH(256)
  ) u_iram (
    .ref_clk(ref_clk),
    .addr(iram_addr),
    .wr_en(iram_we),
    .wr_data(iram_wd),
    .rd_data(iram_rd)
  );

  dmm_ram #(
    .AW(8),
    .DEPTH(256)
  ) u_expanded_ram (
    .ref_clk(ref_clk),
    .addr(xmem_addr[7:0]),
    .wr_en(expanded_ram_hit && xmem_write),
    .wr_data(xmem_wr_data),
    .rd_data(expanded_ram_rd)
  );

  // both pointers share the 83h/84h addresses; only the selected one moves
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_dp
      dmm_data_pointer u_dp (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .sel((gi == 1) ? pointer_select_q : !pointer_select_q),
        .load_high(sfr_wr && sfr_dp_high),
        .load_low(sfr_wr && sfr_dp_low),
        .incr(dp_incr),
        .wr_data(mem_wr_data),
        .value_q(dp_bank[16*gi +: 16])
      );
    end
  endgenerate

  assign first_data_pointer = dp_bank[15:0];
  assign second_data_pointer = dp_bank[31:16];

  assign dp_sel = pointer_select_q ? second_data_pointer : first_data_pointer;

  // status word: software write first, then alu flags, parity always live
  always @*
  begin
    psw_d = psw_q;
    if (psw_wr)
      psw_d = mem_wr_data;
    if (alu_flag_we)
    begin
      psw_d[`DMM_PSW_CARRY] = carry_in;
      psw_d[`DMM_PSW_AUX_CARRY] = aux_carry_in;
      psw_d[`DMM_PSW_OVERFLOW] = overflow_in;
    end
    psw_d[`DMM_PSW_PARITY] = parity;
  end

  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      psw_q <= `DMM_PSW_RESET;
    else
      psw_q <= psw_d;
  end

  // boot enable is caught from the strap on the first clock after reset release
  // the strap is read once only; a later change takes effect at the next reset
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pointer_select_q <= 1'b0;
      general_flag_three_q <= 1'b0;
      boot_flash_map_enable_q <= 1'b0;
      boot_loaded_q <= 1'b0;
    end
    else
    begin
      boot_loaded_q <= 1'b1;
      if (!boot_loaded_q)
        boot_flash_map_enable_q <= !boot_loader_jump_config;
      else if (aux_wr)
      begin
        boot_flash_map_enable_q <= mem_wr_data[`DMM_AUX_BOOT_ENABLE];
        general_flag_three_q <= mem_wr_data[`DMM_AUX_GEN_FLAG];
        pointer_select_q <= mem_wr_data[`DMM_AUX_PTR_SELECT];
      end
      else if (aux_incr)
        pointer_select_q <= !pointer_select_q;
    end
  end

  // registered read answers, one cycle after the request
  // writes to the four local registers also raise the hit flag, so the core sees the access claimed
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_rd_data_q <= 8'h00;
      mem_sfr_hit_q <= 1'b0;
      bit_rd_data_q <= 1'b0;
      xmem_rd_data_q <= 8'h00;
      xmem_hit_q <= 1'b0;
      boot_flash_sel_q <= 1'b0;
      active_data_pointer_q <= 16'h0000;
      processor_status_word_q <= 8'h00;
      auxiliary_control_one_q <= 8'h00;
    end
    else
    begin
      mem_sfr_hit_q <= 1'b0;
      if (direct_upper)
      begin
        if (mem_addr == `DMM_ADDR_DP_HIGH)
        begin
          mem_rd_data_q <= dp_sel[15:8];
          mem_sfr_hit_q <= 1'b1;
        end
        else if (mem_addr == `DMM_ADDR_DP_LOW)
        begin
          mem_rd_data_q <= dp_sel[7:0];
          mem_sfr_hit_q <= 1'b1;
        end
        else if (mem_addr == `DMM_ADDR_AUX_CTRL)
        begin
          mem_rd_data_q <= aux_view;
          mem_sfr_hit_q <= 1'b1;
        end
        else if (mem_addr == `DMM_ADDR_STATUS)
        begin
          mem_rd_data_q <= psw_q;
          mem_sfr_hit_q <= 1'b1;
        end
        else
          mem_rd_data_q <= 8'h00;
      end
      else if (mem_req)
        mem_rd_data_q <= iram_rd;
      if (!mem_req && bit_req)
        bit_rd_data_q <= |(iram_rd & bit_mask);
      xmem_hit_q <= expanded_ram_hit;
      if (expanded_ram_hit)
        xmem_rd_data_q <= expanded_ram_rd;
      boot_flash_sel_q <= boot_flash_map_enable_q && (code_addr >= `DMM_BOOT_BASE);
      active_data_pointer_q <= dp_sel;
      processor_status_word_q <= psw_d;
      auxiliary_control_one_q <= aux_view;
    end
  end
endmodule

// [logic/dmm_regs.vh]
`ifndef DMM_REGS_VH
`define DMM_REGS_VH
// special function register addresses
`define DMM_ADDR_DP_HIGH 8'h83
`define DMM_ADDR_DP_LOW 8'h84
`define DMM_ADDR_AUX_CTRL 8'hA2
`define DMM_ADDR_STATUS 8'hD0
// ram segment boundaries
`define DMM_UPPER_BASE 8'h80
`define DMM_BIT_AREA_BASE 8'h20
`define DMM_BOOT_BASE 16'hF800
// processor status word fields
`define DMM_PSW_CARRY 7
`define DMM_PSW_AUX_CARRY 6
`define DMM_PSW_USER_ZERO 5
`define DMM_PSW_BANK_HIGH 4
`define DMM_PSW_BANK_LOW 3
`define DMM_PSW_OVERFLOW 2
`define DMM_PSW_USER_ONE 1
`define DMM_PSW_PARITY 0
`define DMM_PSW_RESET 8'h00
// auxiliary control fields
`define DMM_AUX_BOOT_ENABLE 5
`define DMM_AUX_GEN_FLAG 3
`define DMM_AUX_ZERO 2
`define DMM_AUX_PTR_SELECT 0
`define DMM_AUX_WRITE_MASK 8'h29
`endif

// [logic/dmm_ram.v]
`timescale 1ns/1ps
// single port byte memory, synchronous write, combinational read
module dmm_ram #(
  parameter AW = 8,
  parameter DEPTH = 256
) (
  // clock
  input wire ref_clk,
  // access
  input wire [AW-1:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  output wire [7:0] rd_data
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[addr] <= wr_data;
  end

  assign rd_data = mem[addr];
endmodule

// [logic/dmm_data_pointer.v]
`timescale 1ns/1ps
`include "dmm_regs.vh"
// one 16-bit data pointer with byte loads and increment
module dmm_data_pointer (
  // clock and reset
  input wire ref_clk,
  input wire rst_b,
  // control
  input wire sel,
  input wire load_high,
  input wire load_low,
  input wire incr,
  input wire [7:0] wr_data,
  // value
  output reg [15:0] value_q
);
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      value_q <= 16'h0000;
    else if (sel)
    begin
      if (incr)
        value_q <= value_q + 16'h0001;
      else
      begin
        if (load_high)
          value_q[15:8] <= wr_data;
        if (load_low)
          value_q[7:0] <= wr_data;
      end
    end
  end
endmodule

// [test/dmm_map_props.sv]
`timescale 1ns/1ps
module dmm_map_props (
  // clock and reset
  input wire ref_clk, rst_b,
  // requests
  input wire mem_req, mem_write, mem_indirect, mem_reg_form, xmem_req, aux_incr,
  input wire alu_flag_we, carry_in, aux_carry_in, overflow_in,
  input wire [7:0] mem_addr, accumulator_register,
  input wire [15:0] xmem_addr, code_addr,
  // answers
  input wire mem_sfr_hit_q, xmem_hit_q, boot_flash_sel_q,
  input wire [7:0] processor_status_word_q, auxiliary_control_one_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_psw_reset_clear: assert property ($rose(rst_b) |-> processor_status_word_q == 8'h00)
    else $error("status word not clear after reset");
  a_aux_reset_bits: assert property ($rose(rst_b) |-> (auxiliary_control_one_q & 8'h05) == 8'h00)
    else $error("aux select or zero bit set after reset");
  a_aux_zero_bit: assert property (auxiliary_control_one_q[2] == 1'b0)
    else $error("aux bit two not zero");
  a_aux_reserved_zero: assert property (auxiliary_control_one_q[7:6] == 2'h0)
    else $error("aux reserved bits not zero");
  a_boot_map_decode: assert property (boot_flash_sel_q ==
    (auxiliary_control_one_q[5] && $past(code_addr) >= 16'hF800)) else $error("boot decode wrong");
  a_select_toggle: assert property (aux_incr && !mem_req |=> ##1
    auxiliary_control_one_q[0] != $past(auxiliary_control_one_q[0])) else $error("select did not toggle");
  a_expanded_ram_range: assert property (xmem_req |=> xmem_hit_q == ($past(xmem_addr) < 16'h0100))
    else $error("expanded_ram hit wrong");
  a_sfr_direct_hit: assert property (mem_req && !mem_write && !mem_indirect && !mem_reg_form |=>
    mem_sfr_hit_q == ($past(mem_addr) inside {8'h83, 8'h84, 8'hA2, 8'hD0})) else $error("sfr hit wrong");
  a_indirect_no_sfr: assert property (mem_req && mem_indirect |=> !mem_sfr_hit_q)
    else $error("indirect access hit sfr");
  a_alu_flag_load: assert property (alu_flag_we && !mem_req |=>
    processor_status_word_q[7] == $past(carry_in) && processor_status_word_q[6] == $past(aux_carry_in)
    && processor_status_word_q[2] == $past(overflow_in)) else $error("alu flags wrong");
  a_parity_follow: assert property ($stable(accumulator_register) |=>
    processor_status_word_q[0] == ^$past(accumulator_register)) else $error("parity wrong");
  c_alu: cover property (alu_flag_we);
  c_toggle: cover property (aux_incr);
  c_boot: cover property (boot_flash_sel_q);
endmodule
bind dmm_data_memory_map dmm_map_props u_props (.*);

// [test/dmm_core_model.sv]
`timescale 1ns/1ps
// byte access side of the core: one request, one answer, then release
module dmm_core_model (
  input wire ref_clk,
  output reg mem_req, mem_write, mem_indirect, mem_reg_form,
  output reg [2:0] mem_reg_index,
  output reg [7:0] mem_addr, mem_wr_data,
  input wire [7:0] mem_rd_data_q
);
  initial {mem_req, mem_write, mem_indirect, mem_reg_form, mem_reg_index, mem_addr, mem_wr_data} = 0;
  task acc(input w, i, r, input [2:0] x, input [7:0] a, d, output [7:0] q);
    @(posedge ref_clk);
    #1;
    {mem_req, mem_write, mem_indirect, mem_reg_form, mem_reg_index, mem_addr} = {1'b1, w, i, r, x, a};
    // never set reserved aux bits 7:6
    mem_wr_data = (a == 8'hA2 && !i && !r) ? d & 8'h3F : d;
    @(posedge ref_clk);
    #1;
    mem_req = 0;
    mem_addr = ~a;
    q = mem_rd_data_q;
  endtask
endmodule

// [test/dmm_data_memory_map_bench.sv]
`timescale 1ns/1ps
module dmm_data_memory_map_bench;
  logic ref_clk, rst_b, boot_loader_jump_config, mem_req, mem_write, mem_indirect, mem_reg_form;
  logic bit_req, bit_write, bit_wr_data, bit_rd_data_q, xmem_req, xmem_write, xmem_hit_q, mem_sfr_hit_q;
  logic dp_incr, aux_incr, alu_flag_we, carry_in, aux_carry_in, overflow_in, boot_flash_sel_q;
  logic [2:0] mem_reg_index;
  logic [6:0] bit_addr;
  logic [7:0] mem_addr, mem_wr_data, mem_rd_data_q, xmem_wr_data, xmem_rd_data_q, accumulator_register, q;
  logic [7:0] processor_status_word_q, auxiliary_control_one_q;
  logic [15:0] xmem_addr, code_addr, active_data_pointer_q;
  int error_cnt = 0, checked = 0;
  dmm_data_memory_map dut (.*);
  dmm_core_model core (.*);
  initial
  begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task complete_run;
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task dw(input [7:0] a, d);
    core.acc(1, 0, 0, 0, a, d, q);
  endtask
  task dr(input [7:0] a);
    core.acc(0, 0, 0, 0, a, 0, q);
  endtask
  task t_reset;
    chk("psw", processor_status_word_q, 8'h00);
    code_addr = 16'hF800;
    tick(2);
    chk("aux", auxiliary_control_one_q & 8'h25, 8'h20);
    chk("boot hi", boot_flash_sel_q, 1);
    code_addr = 16'hF7FF;
    tick(2);
    chk("boot lo", boot_flash_sel_q, 0);
  endtask
  task t_banks;
    for (int b = 0; b < 4; b++)
    begin
      dw(8'hD0, b << 3);
      core.acc(1, 0, 1, 3'h5, 8'h00, 8'h40 + b, q);
      dr(8 * b + 5);
      chk("bank reg", q, 8'h40 + b);
    end
    dw(8'hD0, 8'h00);
  endtask
  task t_segments;
    dw(8'h7F, 8'h5A);
    core.acc(0, 1, 0, 0, 8'h7F, 0, q);
    chk("lower", q, 8'h5A);
    core.acc(1, 1, 0, 0, 8'h80, 8'hA5, q);
    dr(8'h80);
    chk("sfr 80", {mem_sfr_hit_q, q}, 9'h000);
    core.acc(0, 1, 0, 0, 8'h80, 0, q);
    chk("upper", q, 8'hA5);
  endtask
  task t_bits;
    dw(8'h21, 8'h00);
    {bit_req, bit_write, bit_addr, bit_wr_data} = {2'b11, 7'h0B, 1'b1};
    tick();
    bit_write = 0;
    tick();
    bit_req = 0;
    chk("bit rd", bit_rd_data_q, 1);
    dr(8'h21);
    chk("bit byte", q, 8'h08);
  endtask
  task t_expanded_ram;
    {xmem_req, xmem_write, xmem_addr, xmem_wr_data} = {2'b11, 16'h00FF, 8'hC3};
    tick();
    xmem_write = 0;
    tick();
    chk("expanded_ram", {xmem_hit_q, xmem_rd_data_q}, 9'h1C3);
    xmem_addr = 16'h0100;
    tick();
    xmem_req = 0;
    chk("expanded_ram out", xmem_hit_q, 0);
  endtask
  task t_pointers;
    dw(8'h83, 8'h12);
    dw(8'h84, 8'h34);
    aux_incr = 1;
    tick();
    aux_incr = 0;
    dw(8'h83, 8'h56);
    dw(8'h84, 8'h78);
    tick();
    chk("dp1", active_data_pointer_q, 16'h5678);
    aux_incr = 1;
    tick();
    aux_incr = 0;
    tick(2);
    chk("dp0", active_data_pointer_q, 16'h1234);
    dp_incr = 1;
    tick();
    dp_incr = 0;
    tick(2);
    chk("dp inc", active_data_pointer_q, 16'h1235);
    aux_incr = 1;
    tick();
    aux_incr = 0;
    tick(2);
    chk("dp1 kept", active_data_pointer_q, 16'h5678);
  endtask
  task t_rereset;
    dw(8'hA2, 8'h09);
    boot_loader_jump_config = 1;
    rst_b = 0;
    tick(2);
    chk("rst psw", processor_status_word_q, 8'h00);
    rst_b = 1;
    tick(2);
    chk("rst aux", auxiliary_control_one_q, 8'h00);
    chk("rst boot", boot_flash_sel_q, 0);
  endtask
  task t_aux;
    dw(8'hA2, 8'hFF);
    dr(8'hA2);
    chk("aux rd", {mem_sfr_hit_q, q}, 9'h129);
    dw(8'hA2, 8'h00);
    code_addr = 16'hF800;
    tick(2);
    chk("boot off", {boot_flash_sel_q, auxiliary_control_one_q}, 9'h000);
  endtask
  task t_flags;
    {alu_flag_we, carry_in, aux_carry_in, overflow_in} = 4'b1101;
    tick();
    alu_flag_we = 0;
    tick();
    chk("alu", processor_status_word_q & 8'hC4, 8'h84);
    dw(8'hD0, 8'h22);
    tick();
    chk("user", processor_status_word_q & 8'hFE, 8'h22);
    accumulator_register = 8'h07;
    tick(2);
    chk("par odd", processor_status_word_q[0], 1);
  endtask
  initial
  begin
    {rst_b, boot_loader_jump_config, bit_req, bit_write, bit_wr_data, bit_addr, xmem_req, xmem_write} = 0;
    {xmem_addr, xmem_wr_data, dp_incr, aux_incr, alu_flag_we, carry_in, aux_carry_in, overflow_in} = 0;
    {accumulator_register, code_addr} = 0;
    tick(6);
    rst_b = 1;
    tick();
    t_reset;
    t_banks;
    t_segments;
    t_bits;
    t_expanded_ram;
    t_pointers;
    t_aux;
    t_flags;
    t_rereset;
    complete_run;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    complete_run;
  end
endmodule
